//--- core/hbm_interval_timer.sv
/*
 * Qualified interval counter: fires once a condition has held for a set
 * number of cycles and restarts whenever the condition drops.
 * Assumes a single clock and the block's asynchronous active-low reset.
 */
`timescale 1ns/100ps
module hbm_interval_timer import hbm_pkg::*; #(
    parameter int unsigned COUNT = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic qualify,
    output logic expired
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic done;
    } hbm_tmr_s;

    hbm_tmr_s state_q;
    hbm_tmr_s state_d;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

    always_comb begin
        state_d = state_q;
        if (!qualify) begin
            state_d = '0; // [RULE18]
        end else if (!state_q.done) begin
            if (state_q.count == LAST) begin
                state_d.done = 1'b1;
            end else begin
                state_d.count = state_q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign expired = state_q.done;

    property p_restart;
        @(posedge clk) disable iff (!rstn)
        !qualify |=> !expired;
    endproperty
    a_restart: assert property (p_restart) else $error("timer did not restart"); // [RULE18]

endmodule

//--- core/hbm_mode_ctrl.sv
/*
 * Mode and protection control for a brushed DC motor H-bridge: sleep,
 * wake, active and fault modes, latched overcurrent, thermal shutdown.
 * Assumes comparator and supply-monitor levels synchronous to clk and
 * rstn driven low by supply undervoltage lockout.
 */
// Overview of operation
// RULE1 - Sustained overcurrent latches fault, bridge off
// RULE2 - Overcurrent fault clears only by sleep/power
// RULE3 - High and low sides monitored separately
// RULE4 - Sense pin trip shares overcurrent handling
// RULE5 - Over-temperature disables bridge, auto resumes
// RULE6 - Undervoltage resets all logic, bridge off
// RULE7 - Resume only above rising supply threshold
// RULE8 - Active needs supply, input high, wake
// RULE9 - Both inputs low disables bridge, circuits
// RULE10 - Inputs low for entry time: sleep
// RULE11 - Power up with inputs low: sleep
// RULE12 - Wake needs input high beyond wake time
// RULE13 - Overcurrent recovery needs current low, reset
// RULE14 - Leave fault once recovery condition holds
// RULE15 - Input table: coast, reverse, forward, brake
// RULE16 - Deglitch interval typically 1.5 us
// RULE17 - Thermal recovery uses 40 C hysteresis
// RULE18 - Intervals counted, restart on condition drop
`timescale 1ns/100ps
module hbm_mode_ctrl import hbm_pkg::*; #(
    parameter int unsigned SLEEP_CYCLES = SLEEP_ENTRY_CYC,
    parameter int unsigned WAKE_CYCLES = WAKE_CYC,
    parameter int unsigned DEGLITCH_CYCLES = OC_DEGLITCH_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic driveInputA,
    input wire logic driveInputB,
    input wire logic supplyAboveRising,
    input wire hbm_oc_s ocCompare,
    input wire logic tempAboveShutdown,
    input wire logic tempBelowRecovery,
    output hbm_leg_s bridgeOutputA,
    output hbm_leg_s bridgeOutputB,
    output hbm_status_s status
);

    typedef struct packed {
        hbm_mode_e mode;
        logic ocLatched;
        logic thermalHot;
        hbm_leg_s legA;
        hbm_leg_s legB;
        hbm_status_s stat;
    } hbm_ctrl_s;

    hbm_ctrl_s state_q;
    hbm_ctrl_s state_d;

    logic anyHigh;
    logic anyOver;
    logic sleepDue;
    logic wakeDue;
    logic ocDue;

    assign anyHigh = driveInputA | driveInputB;
    assign anyOver = |ocCompare; // [RULE3] [RULE4]

    hbm_interval_timer #(.COUNT(SLEEP_CYCLES)) u_sleep (
        .clk(clk),
        .rstn(rstn),
        .qualify(!anyHigh && state_q.mode != HBM_SLEEP),
        .expired(sleepDue)
    ); // [RULE10] [RULE15]

    hbm_interval_timer #(.COUNT(WAKE_CYCLES)) u_wake (
        .clk(clk),
        .rstn(rstn),
        .qualify(anyHigh && supplyAboveRising && state_q.mode == HBM_WAKING),
        .expired(wakeDue)
    ); // [RULE12]

    hbm_interval_timer #(.COUNT(DEGLITCH_CYCLES)) u_oc (
        .clk(clk),
        .rstn(rstn),
        .qualify(anyOver && state_q.mode == HBM_ACTIVE),
        .expired(ocDue)
    ); // [RULE16] [RULE18]

    always_comb begin
        state_d = state_q;
        // Thermal flag with hysteresis band held by the comparators
        if (tempAboveShutdown) begin
            state_d.thermalHot = 1'b1;
        end else if (tempBelowRecovery) begin
            state_d.thermalHot = 1'b0; // [RULE5] [RULE17]
        end
        case (state_q.mode)
            HBM_SLEEP: begin
                state_d.ocLatched = 1'b0; // [RULE2]
                if (anyHigh && supplyAboveRising) begin
                    state_d.mode = HBM_WAKING; // [RULE7]
                end
            end
            HBM_WAKING: begin
                if (!anyHigh) begin
                    state_d.mode = HBM_SLEEP;
                end else if (wakeDue && state_d.thermalHot) begin
                    // Never drive the bridge for a cycle while already hot
                    state_d.mode = HBM_FAULT; // [RULE5]
                end else if (wakeDue) begin
                    state_d.mode = HBM_ACTIVE; // [RULE8] [RULE12]
                end
            end
            HBM_ACTIVE: begin
                if (ocDue) begin
                    state_d.ocLatched = 1'b1; // [RULE1]
                    state_d.mode = HBM_FAULT;
                end else if (state_d.thermalHot) begin
                    state_d.mode = HBM_FAULT; // [RULE5]
                end else if (sleepDue) begin
                    state_d.mode = HBM_SLEEP; // [RULE10]
                end
            end
            HBM_FAULT: begin
                if (sleepDue) begin
                    // Flag drops together with sleep, never shown stale
                    state_d.ocLatched = 1'b0; // [RULE2]
                    state_d.mode = HBM_SLEEP; // [RULE2] [RULE13]
                end else if (!state_q.ocLatched && !state_d.thermalHot) begin
                    state_d.mode = HBM_ACTIVE; // [RULE14]
                end
            end
            default: state_d.mode = HBM_SLEEP;
        endcase
        // Drive decode; everything off outside active mode
        state_d.legA = LEG_OFF;
        state_d.legB = LEG_OFF;
        if (state_d.mode == HBM_ACTIVE) begin
            case ({driveInputA, driveInputB})
                2'b01: begin
                    state_d.legA = LEG_LOW;
                    state_d.legB = LEG_HIGH;
                end
                2'b10: begin
                    state_d.legA = LEG_HIGH;
                    state_d.legB = LEG_LOW;
                end
                2'b11: begin
                    state_d.legA = LEG_LOW;
                    state_d.legB = LEG_LOW;
                end
                default: begin
                    state_d.legA = LEG_OFF;
                    state_d.legB = LEG_OFF;
                end
            endcase // [RULE15] [RULE1]
        end
        state_d.stat.mode = state_d.mode;
        state_d.stat.overcurrentFault = state_d.ocLatched;
        state_d.stat.thermalShutdown = state_d.thermalHot;
        state_d.stat.circuitsOn = (state_d.mode != HBM_SLEEP); // [RULE9]
    end

    // Supply lockout drives rstn, so all logic returns to sleep state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= '0; // [RULE6] [RULE11]
        end else begin
            state_q <= state_d;
        end
    end

    assign bridgeOutputA = state_q.legA;
    assign bridgeOutputB = state_q.legB;
    assign status = state_q.stat;

    property p_fault_off;
        @(posedge clk) disable iff (!rstn)
        state_q.mode == HBM_FAULT |-> bridgeOutputA == LEG_OFF && bridgeOutputB == LEG_OFF;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("bridge on in fault"); // [RULE1]

    property p_oc_latched;
        @(posedge clk) disable iff (!rstn)
        state_q.ocLatched && state_q.mode == HBM_FAULT |=> state_q.ocLatched || $past(sleepDue);
    endproperty
    a_oc_latched: assert property (p_oc_latched) else $error("oc latch lost"); // [RULE2]

    property p_trip;
        @(posedge clk) disable iff (!rstn)
        ocDue && state_q.mode == HBM_ACTIVE |=> state_q.mode == HBM_FAULT && state_q.ocLatched;
    endproperty
    a_trip: assert property (p_trip) else $error("no trip after deglitch"); // [RULE4]

    property p_hot;
        @(posedge clk) disable iff (!rstn)
        tempAboveShutdown |=> bridgeOutputA == LEG_OFF && bridgeOutputB == LEG_OFF;
    endproperty
    a_hot: assert property (p_hot) else $error("bridge on while hot"); // [RULE5]

    property p_reset_state;
        @(posedge clk) $rose(rstn) |-> state_q.mode == HBM_SLEEP && !state_q.ocLatched;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after lockout"); // [RULE6]

    property p_sleep_low;
        @(posedge clk) disable iff (!rstn)
        state_q.mode == HBM_SLEEP |-> !status.circuitsOn && bridgeOutputA == LEG_OFF;
    endproperty
    a_sleep_low: assert property (p_sleep_low) else $error("sleep not quiet"); // [RULE9]

    property p_active_needs;
        @(posedge clk) disable iff (!rstn)
        $past(state_q.mode) == HBM_WAKING && state_q.mode == HBM_ACTIVE |-> $past(wakeDue);
    endproperty
    a_active_needs: assert property (p_active_needs) else $error("active before wake"); // [RULE8]

    property p_forward;
        @(posedge clk) disable iff (!rstn)
        state_d.mode == HBM_ACTIVE && driveInputA && !driveInputB
            |=> bridgeOutputA == LEG_HIGH && bridgeOutputB == LEG_LOW;
    endproperty
    a_forward: assert property (p_forward) else $error("forward decode wrong"); // [RULE15]

    property p_thermal_resume;
        @(posedge clk) disable iff (!rstn)
        state_q.mode == HBM_FAULT && !state_q.ocLatched && !tempAboveShutdown
            && tempBelowRecovery && !sleepDue |=> state_q.mode == HBM_ACTIVE;
    endproperty
    a_thermal_resume: assert property (p_thermal_resume) else $error("no resume"); // [RULE14]

endmodule

//--- core/hbm_pkg.sv
/*
 * Package for the H-bridge mode and fault controller: timing constants,
 * mode encoding, drive states and the grouped status/comparator carriers.
 * Assumes a 10 MHz core clock.
 */
package hbm_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;

    // Interval figures in their own units
    localparam int unsigned SLEEP_ENTRY_US = 1000;
    localparam int unsigned OC_DEGLITCH_NS = 1500;
    localparam int unsigned WAKE_US = 1;

    // Least times round up, never below one cycle
    localparam int unsigned SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_US * (CLK_HZ / 1_000_000) < 1) ? 1 : SLEEP_ENTRY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OC_DEGLITCH_CYC =
        ((OC_DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1) ? 1 :
        (OC_DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned WAKE_CYC =
        (WAKE_US * (CLK_HZ / 1_000_000) < 1) ? 1 : WAKE_US * (CLK_HZ / 1_000_000);

    localparam int unsigned CNT_W = 16;

    typedef enum logic [1:0] {
        HBM_SLEEP  = 2'b00,
        HBM_WAKING = 2'b01,
        HBM_ACTIVE = 2'b10,
        HBM_FAULT  = 2'b11
    } hbm_mode_e;

    // Half-bridge drive: high-side and low-side gate enables
    typedef struct packed {
        logic highOn;
        logic lowOn;
    } hbm_leg_s;

    localparam hbm_leg_s LEG_OFF = 2'b00;
    localparam hbm_leg_s LEG_HIGH = 2'b10;
    localparam hbm_leg_s LEG_LOW = 2'b01;

    typedef struct packed {
        logic highSideA;
        logic lowSideA;
        logic highSideB;
        logic lowSideB;
        logic senseTrip;
    } hbm_oc_s;

    typedef struct packed {
        hbm_mode_e mode;
        logic overcurrentFault;
        logic thermalShutdown;
        logic circuitsOn;
    } hbm_status_s;

endpackage

//--- tb/hbm_host_model.sv
/*
 * Behavioural controller that drives the two bridge control inputs.
 * Assumes the bench sets the wanted input code just after a rising edge.
 */
`timescale 1ns/100ps
module hbm_host_model import hbm_pkg::*; (
    input wire logic clk,
    input wire logic [1:0] cmd,
    output logic driveInputA,
    output logic driveInputB
);
    // Levels are held until the bench asks for another code
    always_ff @(posedge clk) begin
        {driveInputA, driveInputB} <= cmd;
    end
endmodule

//--- tb/hbm_mode_ctrl_tb_top.sv
/*
 * Self-checking bench for the mode and protection controller.
 * Assumes short sleep counts in the design and the host model as partner.
 */
`timescale 1ns/100ps
module hbm_mode_ctrl_tb_top;
    import hbm_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic supplyOk = 1'b1;
    logic hot = 1'b0;
    logic cool = 1'b1;
    logic [1:0] cmd = 2'h0;
    hbm_oc_s oc = '0;
    logic inA;
    logic inB;
    hbm_leg_s legA;
    hbm_leg_s legB;
    hbm_status_s st;
    int bad_count = 0;
    int samples_checked = 0;

    hbm_host_model u_hbm_host_model (.clk(clk), .cmd(cmd), .driveInputA(inA), .driveInputB(inB));
    hbm_mode_ctrl #(.SLEEP_CYCLES(20), .WAKE_CYCLES(10), .DEGLITCH_CYCLES(15)) u_hbm_mode_ctrl (
        .clk(clk), .rstn(rstn), .driveInputA(inA), .driveInputB(inB),
        .supplyAboveRising(supplyOk), .ocCompare(oc), .tempAboveShutdown(hot),
        .tempBelowRecovery(cool), .bridgeOutputA(legA), .bridgeOutputB(legB), .status(st));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_mode(hbm_mode_e m, int limit);
        int i;
        for (i = 0; i < limit && st.mode !== m; i++) tick(1);
        chk("mode", 8'(st.mode), 8'(m));
    endtask

    task automatic set_cmd(logic [1:0] c, int n);
        @(posedge clk);
        cmd <= c;
        tick(n);
    endtask

    task automatic chk_legs(hbm_leg_s a, hbm_leg_s b);
        chk("legs", {4'h0, legA, legB}, {4'h0, a, b});
    endtask

    task automatic t_powerup;
        tick(5);
        chk("mode", 8'(st.mode), 8'(HBM_SLEEP));
        chk_legs(LEG_OFF, LEG_OFF);
    endtask

    task automatic t_wake_table;
        set_cmd(2'h2, 4);
        chk("mode", 8'(st.mode), 8'(HBM_WAKING));
        chk_legs(LEG_OFF, LEG_OFF);
        wait_mode(HBM_ACTIVE, 30);
        chk("circuits", 8'(st.circuitsOn), 8'h01);
        tick(2);
        chk_legs(LEG_HIGH, LEG_LOW);
        set_cmd(2'h1, 3);
        chk_legs(LEG_LOW, LEG_HIGH);
        set_cmd(2'h3, 3);
        chk_legs(LEG_LOW, LEG_LOW);
        set_cmd(2'h0, 12);
        chk_legs(LEG_OFF, LEG_OFF);
        // Brief drive restarts the sleep count
        set_cmd(2'h2, 2);
        set_cmd(2'h0, 15);
        chk("mode", 8'(st.mode), 8'(HBM_ACTIVE));
        wait_mode(HBM_SLEEP, 30);
        chk("circuits", 8'(st.circuitsOn), 8'h00);
    endtask

    task automatic t_overcurrent;
        int b;
        for (b = 0; b < 5; b++) begin
            set_cmd(2'h2, 1);
            wait_mode(HBM_ACTIVE, 30);
            @(posedge clk);
            oc <= hbm_oc_s'(5'h01 << b);
            tick(10);
            @(posedge clk);
            oc <= '0;
            tick(3);
            chk("mode", 8'(st.mode), 8'(HBM_ACTIVE));
            @(posedge clk);
            oc <= hbm_oc_s'(5'h01 << b);
            tick(20);
            chk("mode", 8'(st.mode), 8'(HBM_FAULT));
            chk("ocFlag", 8'(st.overcurrentFault), 8'h01);
            chk_legs(LEG_OFF, LEG_OFF);
            @(posedge clk);
            oc <= '0;
            set_cmd(2'h1, 10);
            chk("mode", 8'(st.mode), 8'(HBM_FAULT));
            set_cmd(2'h0, 1);
            wait_mode(HBM_SLEEP, 40);
            chk("ocFlag", 8'(st.overcurrentFault), 8'h00);
        end
    endtask

    task automatic t_thermal;
        set_cmd(2'h1, 1);
        wait_mode(HBM_ACTIVE, 30);
        @(posedge clk);
        hot <= 1'b1;
        cool <= 1'b0;
        tick(3);
        chk("mode", 8'(st.mode), 8'(HBM_FAULT));
        chk("tsd", {6'h0, st.thermalShutdown, st.circuitsOn}, 8'h03);
        chk_legs(LEG_OFF, LEG_OFF);
        @(posedge clk);
        hot <= 1'b0;
        tick(5);
        chk("mode", 8'(st.mode), 8'(HBM_FAULT));
        @(posedge clk);
        cool <= 1'b1;
        tick(3);
        chk("mode", 8'(st.mode), 8'(HBM_ACTIVE));
        chk_legs(LEG_LOW, LEG_HIGH);
    endtask

    task automatic t_undervoltage;
        @(posedge clk);
        rstn <= 1'b0;
        supplyOk <= 1'b0;
        tick(2);
        chk("mode", 8'(st.mode), 8'(HBM_SLEEP));
        chk_legs(LEG_OFF, LEG_OFF);
        @(posedge clk);
        rstn <= 1'b1;
        tick(20);
        chk("notActive", 8'(st.mode == HBM_ACTIVE), 8'h00);
        @(posedge clk);
        supplyOk <= 1'b1;
        wait_mode(HBM_ACTIVE, 30);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Tests need well under 2000 cycles
    initial begin
        #(100 * 20000);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_powerup();
        t_wake_table();
        t_overcurrent();
        t_thermal();
        t_undervoltage();
        final_report();
    end
endmodule
